// ===== common/hscv_pkg.sv
// constants and carriers for the counter configuration validator
`default_nettype none
package hscv_pkg;
	localparam int unsigned NUM_CHAN = 2;
	localparam int unsigned NUM_OUT  = 4;
	// counter operating modes and the mode and storage limits as coded in the configuration
	localparam logic [2:0] MODE_FREQ   = 3'h3;
	localparam logic [2:0] MODE_PERIOD = 3'h4;
	localparam logic [2:0] MODE_CONT   = 3'h5;
	localparam logic [2:0] MODE_LIMIT  = 3'h7;
	localparam logic [2:0] STORE_LIMIT = 3'h6;
	// value limits
	localparam logic [31:0] LIMIT_24BIT     = 32'h00FF_FFFE;
	localparam logic [15:0] SCALE_FREQ_MAX  = 16'h07D0;
	localparam logic [15:0] SCALE_FREQ_STEP = 16'h000A;
	localparam logic [15:0] SCALE_RATE_MAX  = 16'h0100;
	localparam logic [3:0]  TIE_MAX         = 4'h2;
	localparam logic [3:0]  ACTION_MAX      = 4'h2;
	// error classes, second-lowest digit of the code (bits 7:4)
	localparam logic [3:0] ERR_COUNTER_MODE   = 4'h1;
	localparam logic [3:0] ERR_STORAGE_MODE   = 4'h2;
	localparam logic [3:0] ERR_ROLLOVER_VALUE = 4'h3;
	localparam logic [3:0] ERR_PRESET_VALUE   = 4'h4;
	localparam logic [3:0] ERR_SCALER_VALUE   = 4'h5;
	localparam logic [3:0] ERR_OUTPUT_TIE     = 4'h6;
	localparam logic [3:0] ERR_FAULT_ACTION   = 4'h7;
	localparam logic [3:0] ERR_PROGRAM_ACTION = 4'h8;
	localparam logic [3:0] ERR_WINDOW_LIMIT   = 4'h9;
	localparam int unsigned NUM_CLASS = 9;
	localparam logic [15:0] ERR_NONE = 16'h0000;
	// reset values
	localparam logic [15:0] CODE_RST = 16'h0000;

	typedef struct packed {
		logic [2:0]  mode;
		logic [2:0]  storage;
		logic [31:0] rollover;
		logic [31:0] preset;
		logic [15:0] scaler;
	} hscv_chan_cfg_t;

	typedef struct packed {
		logic [3:0]  tie;
		logic [3:0]  fault_action;
		logic [3:0]  program_action;
		logic [31:0] on_limit;
		logic [31:0] off_limit;
	} hscv_out_cfg_t;

	typedef struct packed {
		hscv_chan_cfg_t [NUM_CHAN-1:0] chan;
		hscv_out_cfg_t  [NUM_OUT-1:0]  outp;
	} hscv_cfg_t;

	typedef struct packed {
		logic keying_en;
		logic identity_match;
		logic size_ok;
		logic format_ok;
	} hscv_conn_req_t;

	typedef enum logic [0:0] {
		ST_IDLE  = 1'b0,
		ST_CHECK = 1'b1
	} hscv_state_t;
endpackage
`default_nettype wire

// ===== test/hscv_ctrl_model.sv
// controller side model: hands over whole configurations
`default_nettype none
module hscv_ctrl_model (
	input  wire logic               core_clk_i,
	input  wire logic               send_i,
	input  wire hscv_pkg::hscv_cfg_t data_i,
	output var  logic               cfg_load_o,
	output var  hscv_pkg::hscv_cfg_t cfg_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import hscv_pkg::*;
	hscv_cfg_t last_q;
	always_ff @(posedge core_clk_i) begin
		if (send_i) begin
			last_q <= data_i;
		end
	end
	// whole struct in the load cycle, inverted junk otherwise
	assign cfg_load_o = send_i;
	assign cfg_o      = send_i ? data_i : ~last_q;
endmodule
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the configuration validator
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import hscv_pkg::*;
	logic           core_clk_i = 1'b0;
	logic           rst_n_i = 1'b0;
	logic           send = 1'b0;
	logic           cfg_load;
	logic           comm_fault = 1'b0;
	logic           run_mode = 1'b0;
	logic           conn_req = 1'b0;
	logic           done, err, applied, acc, rej;
	logic [15:0]    code;
	hscv_cfg_t      data = '0;
	hscv_cfg_t      cfg, base, c;
	hscv_conn_req_t conn = '0;
	int             bad_count = 0;
	int             check_count = 0;
	initial begin
		forever #20 core_clk_i = ~core_clk_i;
	end
	hscv_ctrl_model u_ctrl (.core_clk_i(core_clk_i), .send_i(send), .data_i(data),
		.cfg_load_o(cfg_load), .cfg_o(cfg));
	hscv_validator DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cfg_load_i(cfg_load),
		.cfg_i(cfg), .comm_fault_i(comm_fault), .run_mode_i(run_mode),
		.conn_req_i(conn_req), .conn_i(conn), .cfg_done_o(done), .cfg_err_o(err),
		.extended_error_field_o(code), .cfg_applied_o(applied),
		.conn_accept_o(acc), .conn_reject_o(rej));
	task automatic close_out;
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// done is fixed at one edge after the taking edge
	task automatic chk_cfg(input hscv_cfg_t v, input logic [15:0] e);
		@(negedge core_clk_i);
		send = 1'b1;
		data = v;
		@(negedge core_clk_i);
		send = 1'b0;
		// done stands only in the cycle after the check edge
		@(negedge core_clk_i);
		cmp({15'h0, done}, 16'h0001);
		cmp(code, e);
		cmp({15'h0, err}, {15'h0, e !== ERR_NONE});
		cmp({15'h0, applied}, {15'h0, e === ERR_NONE});
	endtask
	initial begin
		repeat (5000) @(posedge core_clk_i);
		bad_count++;
		close_out;
	end
	initial begin
		base = '0;
		for (int i = 0; i < NUM_CHAN; i++) begin
			base.chan[i].rollover = 32'h0000_0064;
			base.chan[i].preset = 32'h0000_0005;
		end
		for (int i = 0; i < NUM_OUT; i++) begin
			base.outp[i].tie = 4'h1;
			base.outp[i].on_limit = 32'h0000_000A;
		end
		repeat (12) @(negedge core_clk_i);
		cmp(code, CODE_RST);
		rst_n_i = 1'b1;
		chk_cfg(base, ERR_NONE);
		c = base;
		c.chan[0].mode = 3'h7;
		chk_cfg(c, 16'h0011);
		c = base;
		c.chan[1].mode = 3'h7;
		c.outp[0].on_limit = 32'h00FF_FFFF;
		chk_cfg(c, 16'h0012);
		c = base;
		c.chan[1].storage = 3'h6;
		chk_cfg(c, 16'h0022);
		c = base;
		c.chan[0].mode = MODE_FREQ;
		c.chan[0].storage = 3'h1;
		chk_cfg(c, 16'h0021);
		c = base;
		c.chan[1].mode = MODE_FREQ;
		c.chan[1].storage = 3'h2;
		chk_cfg(c, 16'h0022);
		c = base;
		c.chan[1].rollover = 32'h00FF_FFFF;
		chk_cfg(c, 16'h0032);
		c.chan[1].rollover = 32'h00FF_FFFE;
		chk_cfg(c, ERR_NONE);
		c = base;
		c.chan[0].mode = MODE_PERIOD;
		chk_cfg(c, 16'h0031);
		c = base;
		c.chan[1].preset = 32'h0000_0064;
		chk_cfg(c, 16'h0042);
		c = base;
		c.chan[0].mode = MODE_FREQ;
		c.chan[0].scaler = 16'h07DA;
		chk_cfg(c, 16'h0051);
		c.chan[0].scaler = 16'h07D0;
		chk_cfg(c, ERR_NONE);
		c.chan[0].scaler = 16'h000F;
		chk_cfg(c, 16'h0051);
		c = base;
		c.chan[1].scaler = 16'h0001;
		chk_cfg(c, 16'h0052);
		c = base;
		c.chan[0].mode = MODE_PERIOD;
		c.chan[0].rollover = 32'h0000_0000;
		c.chan[0].preset = 32'h0000_0000;
		c.chan[0].scaler = 16'h0003;
		chk_cfg(c, 16'h0051);
		c.chan[0].scaler = 16'h0100;
		c.chan[1] = c.chan[0];
		c.chan[1].mode = MODE_CONT;
		c.chan[1].scaler = 16'h0001;
		chk_cfg(c, ERR_NONE);
		c.chan[1].scaler = 16'h0200;
		chk_cfg(c, 16'h0052);
		c.chan[1].scaler = 16'h0000;
		c.chan[1].preset = 32'h0000_0001;
		chk_cfg(c, 16'h0042);
		c = base;
		c.outp[3].tie = 4'h3;
		chk_cfg(c, 16'h0064);
		c = base;
		c.outp[1].fault_action = 4'h3;
		chk_cfg(c, 16'h0072);
		c = base;
		c.outp[2].program_action = 4'h3;
		chk_cfg(c, 16'h0083);
		c = base;
		c.outp[3].off_limit = 32'h00FF_FFFF;
		chk_cfg(c, 16'h0094);
		comm_fault = 1'b1;
		repeat (4) @(negedge core_clk_i);
		chk_cfg(base, ERR_NONE);
		run_mode = 1'b1;
		repeat (4) @(negedge core_clk_i);
		chk_cfg(base, 16'h0071);
		comm_fault = 1'b0;
		// back-to-back requests, every keying and format combination
		for (int k = 0; k <= 16; k++) begin
			@(negedge core_clk_i);
			if (k > 0) begin
				cmp({15'h0, acc}, {15'h0, (!conn.keying_en || conn.identity_match)
					&& conn.size_ok && conn.format_ok});
				cmp({15'h0, rej}, {15'h0, !((!conn.keying_en || conn.identity_match)
					&& conn.size_ok && conn.format_ok)});
			end
			conn_req = (k < 16);
			conn = hscv_conn_req_t'(k[3:0]);
		end
		close_out;
	end
endmodule
`default_nettype wire

// ===== verilog/hscv_validator.sv
// configuration checker and connection gate for a two-channel counter
`default_nettype none
module hscv_validator (
	input  wire logic                    core_clk_i,
	input  wire logic                    rst_n_i,
	input  wire logic                    cfg_load_i,
	input  wire hscv_pkg::hscv_cfg_t     cfg_i,
	input  wire logic                    comm_fault_i,
	input  wire logic                    run_mode_i,
	input  wire logic                    conn_req_i,
	input  wire hscv_pkg::hscv_conn_req_t conn_i,
	output var  logic                    cfg_done_o,
	output var  logic                    cfg_err_o,
	output var  logic [15:0]             extended_error_field_o,
	output var  logic                    cfg_applied_o,
	output var  logic                    conn_accept_o,
	output var  logic                    conn_reject_o
);
	import hscv_pkg::*;

	hscv_state_t state_q, state_d;
	hscv_cfg_t   cfg_q, cfg_d;
	logic        done_q, done_d;
	logic        err_q, err_d;
	logic [15:0] code_q, code_d;
	logic        applied_q, applied_d;
	logic        acc_q, acc_d;
	logic        rej_q, rej_d;
	logic        flt_meta_q, flt_sync_q;
	logic        run_meta_q, run_sync_q;

	logic [NUM_CHAN-1:0] bad_mode, bad_store, bad_roll, bad_pre, bad_scale;
	logic [NUM_OUT-1:0]  bad_tie, bad_flt, bad_prog, bad_win;
	logic                run_fault;
	logic                any_err;
	logic [15:0]         first_code;

	// pins from outside the clock domain pass two flops first
	assign run_fault = flt_sync_q & run_sync_q;

	genvar gc;
	generate
		for (gc = 0; gc < NUM_CHAN; gc++) begin : g_chan
			logic        is_freq, is_rate, is_cnt;
			logic [15:0] sc;
			assign sc      = cfg_q.chan[gc].scaler;
			assign is_freq = cfg_q.chan[gc].mode == MODE_FREQ;
			assign is_rate = (cfg_q.chan[gc].mode == MODE_PERIOD) ||
				(cfg_q.chan[gc].mode == MODE_CONT);
			assign is_cnt  = !is_freq && !is_rate;
			assign bad_mode[gc]  = cfg_q.chan[gc].mode >= MODE_LIMIT;
			assign bad_store[gc] = (cfg_q.chan[gc].storage >= STORE_LIMIT) ||
				(is_freq && (cfg_q.chan[gc].storage != 3'h0));
			assign bad_roll[gc]  = (cfg_q.chan[gc].rollover > LIMIT_24BIT) ||
				(is_rate && (cfg_q.chan[gc].rollover != 32'h0000_0000));
			// rollover zero makes any preset illegal outside the rate modes
			// rate modes force rollover to zero, so only the zero check applies there
			assign bad_pre[gc]   = (!is_rate &&
				(cfg_q.chan[gc].preset >= cfg_q.chan[gc].rollover)) ||
				(is_rate && (cfg_q.chan[gc].preset != 32'h0000_0000));
			assign bad_scale[gc] =
				(is_freq && (sc > SCALE_FREQ_MAX)) ||
				(is_freq && ((sc % SCALE_FREQ_STEP) != 16'h0000)) ||
				(is_cnt && (sc != 16'h0000)) ||
				(is_rate && ((sc > SCALE_RATE_MAX) ||
				((sc & (sc - 16'h0001)) != 16'h0000)));
		end
		for (gc = 0; gc < NUM_OUT; gc++) begin : g_out
			assign bad_tie[gc]  = cfg_q.outp[gc].tie > TIE_MAX;
			assign bad_flt[gc]  = (cfg_q.outp[gc].fault_action > ACTION_MAX) ||
				run_fault;
			assign bad_prog[gc] = cfg_q.outp[gc].program_action > ACTION_MAX;
			assign bad_win[gc]  = (cfg_q.outp[gc].on_limit > LIMIT_24BIT) ||
				(cfg_q.outp[gc].off_limit > LIMIT_24BIT);
		end
	endgenerate

	// lowest class first, then lowest channel or output
	always_comb begin
		logic [NUM_CLASS-1:0][3:0] cls;
		logic                      found;
		cls   = {bad_win, bad_prog, bad_flt, bad_tie, {2'b00, bad_scale},
			{2'b00, bad_pre}, {2'b00, bad_roll}, {2'b00, bad_store}, {2'b00, bad_mode}};
		found = 1'b0;
		first_code = ERR_NONE;
		for (int k = 0; k < NUM_CLASS; k++) begin
			for (int i = 0; i < NUM_OUT; i++) begin
				if (!found && cls[k][i]) begin
					found = 1'b1;
					// low digit is index plus one for channels and outputs
					first_code = {8'h00, 4'(k + 1), 4'(i + 1)};
				end
			end
		end
		any_err = found;
	end

	always_comb begin
		state_d   = state_q;
		cfg_d     = cfg_q;
		done_d    = 1'b0;
		err_d     = err_q;
		code_d    = code_q;
		applied_d = applied_q;
		acc_d     = 1'b0;
		rej_d     = 1'b0;
		case (state_q)
			ST_IDLE: begin
				// a load is only taken whole; partial edits never reach the checker
				if (cfg_load_i) begin
					cfg_d   = cfg_i;
					state_d = ST_CHECK;
				end
			end
			ST_CHECK: begin
				done_d    = 1'b1;
				err_d     = any_err;
				code_d    = first_code;
				applied_d = !any_err;
				state_d   = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (conn_req_i) begin
			// identity ignored with keying off, size and format never are
			if ((!conn_i.keying_en || conn_i.identity_match) &&
				conn_i.size_ok && conn_i.format_ok) begin
				acc_d = 1'b1;
			end else begin
				rej_d = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q    <= ST_IDLE;
			cfg_q      <= '0;
			done_q     <= 1'b0;
			err_q      <= 1'b0;
			code_q     <= CODE_RST;
			applied_q  <= 1'b0;
			acc_q      <= 1'b0;
			rej_q      <= 1'b0;
			flt_meta_q <= 1'b0;
			flt_sync_q <= 1'b0;
			run_meta_q <= 1'b0;
			run_sync_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			cfg_q      <= cfg_d;
			done_q     <= done_d;
			err_q      <= err_d;
			code_q     <= code_d;
			applied_q  <= applied_d;
			acc_q      <= acc_d;
			rej_q      <= rej_d;
			flt_meta_q <= comm_fault_i;
			flt_sync_q <= flt_meta_q;
			run_meta_q <= run_mode_i;
			run_sync_q <= run_meta_q;
		end
	end

	assign cfg_done_o             = done_q;
	assign cfg_err_o              = err_q;
	assign extended_error_field_o = code_q;
	assign cfg_applied_o          = applied_q;
	assign conn_accept_o          = acc_q;
	assign conn_reject_o          = rej_q;

	sequence s_load_idle;
		cfg_load_i && (state_q == ST_IDLE);
	endsequence
	sequence s_answer;
		##2 cfg_done_o;
	endsequence

	a_load_answer: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		s_load_idle |-> s_answer)
		else $error("load not answered two cycles later");
	a_applied_clean: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cfg_done_o |-> (cfg_applied_o == !cfg_err_o))
		else $error("applied flag disagrees with error");
	a_mode_code: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(state_q == ST_CHECK) && (cfg_q.chan[0].mode >= MODE_LIMIT)
		|=> cfg_err_o && (extended_error_field_o == 16'h0011))
		else $error("bad mode on channel 0 not coded 0011");
	a_chan_digit: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cfg_done_o && cfg_err_o && (extended_error_field_o[7:4] <= ERR_SCALER_VALUE)
		|-> extended_error_field_o[3:0] inside {4'h1, 4'h2})
		else $error("channel digit outside 1..2");
	a_out_digit: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cfg_done_o && cfg_err_o && (extended_error_field_o[7:4] >= ERR_OUTPUT_TIE)
		|-> extended_error_field_o[3:0] inside {[4'h1:4'h4]})
		else $error("output digit outside 1..4");
	a_freq_store: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(cfg_q.chan[1].mode == MODE_FREQ) && (cfg_q.chan[1].storage != 3'h0)
		|-> bad_store[1])
		else $error("frequency mode storage not flagged");
	a_rate_scale: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(cfg_q.chan[0].mode == MODE_PERIOD) && (cfg_q.chan[0].scaler == 16'h0003)
		|-> bad_scale[0])
		else $error("rate scaler 3 accepted");
	a_freq_scale: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(cfg_q.chan[0].mode == MODE_FREQ) && (cfg_q.chan[0].scaler == 16'h07D0)
		|-> !bad_scale[0])
		else $error("frequency scaler 2000 rejected");
	a_run_fault: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		comm_fault_i && run_mode_i ##1 (comm_fault_i && run_mode_i) [*2]
		|-> bad_flt[0])
		else $error("comm fault in run not flagged");
	a_conn_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		conn_req_i && !conn_i.keying_en
		|=> (conn_accept_o == $past(conn_i.size_ok && conn_i.format_ok)) &&
		(conn_reject_o != conn_accept_o))
		else $error("keying off connection decided wrongly");
endmodule
`default_nettype wire
